// ==== verilog/ssat_adc_timer.sv ====
// Timing core of a four-channel simultaneous single-slope converter.
// Assumes an AHB-Lite master, a one-cycle sync start strobe from the PWM
// block on hclk, and asynchronous comparator outputs from the analogue side.
//
// Function
// [RULE1] Two mode bits steer auxiliary input multiplexer
// [RULE2] Four channels converted together on one timer
// [RULE3] Twelve-bit timer counts start-to-crossing into result
// [RULE4] Sync pulse discharges ramp, restarts timer at zero
// [RULE5] Mode bit seven selects full or half rate
// [RULE6] Each comparator trip captures timer per channel
// [RULE7] Usable count capped at 4095 or period
// [RULE8] Conversion period follows sync rate, single/double update
// [RULE9] Channel with no trip reports zero
// [RULE10] Software programs sync width to discharge ramp
// [RULE11] Three-bit ramp current trim, resets to zero
// [RULE12] Software calibration loop increments trim against target
// [RULE13] Sample-and-hold strobes at sync pulse falling edge
// [RULE14] Sync width programmable 0.05 to 12.5 us
// [RULE15] Results hold until next sync, read-only
//
// Local design decisions: the AHB-Lite slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module ssat_adc_timer
    import ssat_pkg::*;
(
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic                hready,
    input  wire logic [31:0]         hwdata,
    output logic      [31:0]         hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    input  wire logic                pwm_sync_start,
    input  wire logic [CHANNELS-1:0] comparator_trip,
    output logic                     pwm_sync_pulse,
    output logic                     sample_hold_strobe,
    output logic                     aux_select_high,
    output logic                     aux_select_low,
    output logic      [TRIM_W-1:0]   ramp_current_trim
);

    // ------------------------------------------------------------------
    // Comparator synchronisation
    // ------------------------------------------------------------------
    logic [CHANNELS-1:0] trip_sync;

    ssat_sync #(
        .WIDTH (CHANNELS)
    ) u_trip_sync (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .async_in (comparator_trip),
        .sync_out (trip_sync)
    );

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    ssat_state_t state_reg;
    ssat_state_t state_next;

    logic                accept;
    logic                timer_tick;
    logic [CHANNELS-1:0] trip_rise;
    logic [WIDTH_W-1:0]  width_clamped;

    // ------------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------------
    function automatic logic [31:0] read_word(input ssat_state_t st, input logic [7:0] ofs);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (ofs)
            OFS_MODE: begin
                w[MODE_AUX_MSB:MODE_AUX_LSB] = st.mode.aux_sel;
                w[MODE_RATE_BIT]             = st.mode.rate_fast;
            end
            OFS_SYNC_WT: begin
                w[WIDTH_W-1:0] = st.sync_width;
            end
            OFS_TRIM: begin
                w[TRIM_W-1:0] = st.trim;
            end
            OFS_STATUS: begin
                w[STAT_DISCH_BIT]                            = (st.phase == PH_DISCHARGE);
                w[STAT_CONV_BIT]                             = (st.phase == PH_CONVERT);
                w[STAT_TRIP_LSB+CHANNELS-1:STAT_TRIP_LSB]    = st.tripped;
                w[STAT_TIMER_LSB+TIMER_W-1:STAT_TIMER_LSB]   = st.timer;
            end
            OFS_CAP0: begin
                w[TIMER_W-1:0] = st.result[0];
            end
            OFS_CAP1: begin
                w[TIMER_W-1:0] = st.result[1];
            end
            OFS_CAP2: begin
                w[TIMER_W-1:0] = st.result[2];
            end
            OFS_CAP3: begin
                w[TIMER_W-1:0] = st.result[3];
            end
            default: begin
                w = 32'h0000_0000;
            end
        endcase
        return w;
    endfunction : read_word

    // ------------------------------------------------------------------
    // Helper terms
    // ------------------------------------------------------------------
    assign accept     = hsel && htrans[1] && hready;
    assign timer_tick = state_reg.mode.rate_fast || state_reg.div_tick; // [RULE5]
    assign trip_rise  = trip_sync & ~state_reg.trip_prev;

    always_comb begin
        if (state_reg.sync_width < SYNC_MIN_CYC) begin
            width_clamped = SYNC_MIN_CYC; // [RULE14]
        end else if (state_reg.sync_width > SYNC_MAX_CYC) begin
            width_clamped = SYNC_MAX_CYC; // [RULE14]
        end else begin
            width_clamped = state_reg.sync_width;
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        state_next           = state_reg;
        state_next.sh_strobe = 1'b0;
        state_next.trip_prev = trip_sync;
        state_next.div_tick  = ~state_reg.div_tick;

        // Bus write data phase
        if (state_reg.wr_pend) begin
            case (state_reg.wr_ofs)
                OFS_MODE: begin
                    state_next.mode.aux_sel   = hwdata[MODE_AUX_MSB:MODE_AUX_LSB]; // [RULE1]
                    state_next.mode.rate_fast = hwdata[MODE_RATE_BIT]; // [RULE5]
                end
                OFS_SYNC_WT: begin
                    state_next.sync_width = hwdata[WIDTH_W-1:0]; // [RULE14]
                end
                OFS_TRIM: begin
                    state_next.trim = hwdata[TRIM_W-1:0]; // [RULE11]
                end
                default: begin
                    state_next.trim = state_reg.trim; // [RULE15]
                end
            endcase
        end

        // Conversion cycle
        if (pwm_sync_start) begin
            for (int i = 0; i < CHANNELS; i++) begin
                state_next.result[i] = state_reg.tripped[i] ? state_reg.work[i]
                                                            : TIMER_ZERO; // [RULE9]
                state_next.work[i]   = TIMER_ZERO;
            end
            state_next.tripped   = '0; // [RULE15]
            state_next.phase     = PH_DISCHARGE; // [RULE8]
            state_next.width_cnt = width_clamped - SYNC_MIN_CYC;
            state_next.sync_out  = 1'b1; // [RULE4]
            state_next.timer     = TIMER_ZERO; // [RULE4]
        end else begin
            case (state_reg.phase)
                PH_IDLE: begin
                    state_next.sync_out = 1'b0;
                end
                PH_DISCHARGE: begin
                    if (state_reg.width_cnt == '0) begin
                        state_next.phase     = PH_CONVERT;
                        state_next.sync_out  = 1'b0;
                        state_next.sh_strobe = 1'b1; // [RULE13]
                        state_next.timer     = TIMER_ZERO; // [RULE4]
                        state_next.div_tick  = 1'b0;
                    end else begin
                        state_next.width_cnt = state_reg.width_cnt - 1'b1;
                    end
                end
                PH_CONVERT: begin
                    if (timer_tick && state_reg.timer != TIMER_MAX) begin
                        state_next.timer = state_reg.timer + 1'b1; // [RULE3] [RULE7]
                    end
                    for (int i = 0; i < CHANNELS; i++) begin
                        if (trip_rise[i] && !state_reg.tripped[i]) begin
                            state_next.work[i]    = state_reg.timer; // [RULE2] [RULE6]
                            state_next.tripped[i] = 1'b1;
                        end
                    end
                end
                default: begin
                    state_next.phase = PH_IDLE;
                end
            endcase
        end

        // Bus address phase
        state_next.wr_pend = accept && hwrite;
        state_next.wr_ofs  = {haddr[7:2], 2'b00};
        if (accept && !hwrite) begin
            state_next.rdata = read_word(state_next, {haddr[7:2], 2'b00});
        end else begin
            state_next.rdata = 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg                <= '0;
            state_reg.mode.aux_sel   <= AUX_RESET;
            state_reg.trim           <= TRIM_RESET; // [RULE11]
            state_reg.sync_width     <= WIDTH_RESET;
            state_reg.phase          <= PH_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign hrdata             = state_reg.rdata;
    assign hreadyout          = 1'b1;
    assign hresp              = 1'b0;
    assign pwm_sync_pulse     = state_reg.sync_out;
    assign sample_hold_strobe = state_reg.sh_strobe;
    assign aux_select_high    = state_reg.mode.aux_sel[MODE_AUX_MSB]; // [RULE1]
    assign aux_select_low     = state_reg.mode.aux_sel[MODE_AUX_LSB]; // [RULE1]
    assign ramp_current_trim  = state_reg.trim;

endmodule : ssat_adc_timer

`default_nettype wire

// ==== common/ssat_pkg.sv ====
// Constants, field layouts and state types of the single-slope converter timer.
// Assumes a 20 MHz system clock and a 32-bit AHB-Lite register window.

package ssat_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 50;
    localparam int SYNC_MIN_NS    = 50;
    localparam int SYNC_MAX_NS    = 12500;
    localparam int SYNC_MIN_CYC_I = (SYNC_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_MAX_CYC_I = SYNC_MAX_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int CHANNELS = 4;
    localparam int TIMER_W  = 12;
    localparam int WIDTH_W  = 8;
    localparam int TRIM_W   = 3;
    localparam int AUX_W    = 2;

    localparam logic [WIDTH_W-1:0] SYNC_MIN_CYC = WIDTH_W'(SYNC_MIN_CYC_I);
    localparam logic [WIDTH_W-1:0] SYNC_MAX_CYC = WIDTH_W'(SYNC_MAX_CYC_I);
    localparam logic [TIMER_W-1:0] TIMER_MAX    = 12'hFFF;
    localparam logic [TIMER_W-1:0] TIMER_ZERO   = 12'h000;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_MODE    = 8'h00;
    localparam logic [7:0] OFS_SYNC_WT = 8'h04;
    localparam logic [7:0] OFS_TRIM    = 8'h08;
    localparam logic [7:0] OFS_STATUS  = 8'h0C;
    localparam logic [7:0] OFS_CAP0    = 8'h10;
    localparam logic [7:0] OFS_CAP1    = 8'h14;
    localparam logic [7:0] OFS_CAP2    = 8'h18;
    localparam logic [7:0] OFS_CAP3    = 8'h1C;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int MODE_AUX_LSB    = 0;
    localparam int MODE_AUX_MSB    = 1;
    localparam int MODE_RATE_BIT   = 7;
    localparam int STAT_DISCH_BIT  = 0;
    localparam int STAT_CONV_BIT   = 1;
    localparam int STAT_TRIP_LSB   = 4;
    localparam int STAT_TIMER_LSB  = 16;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [AUX_W-1:0]   AUX_RESET   = 2'h0;
    localparam logic [TRIM_W-1:0]  TRIM_RESET  = 3'h0;
    localparam logic [WIDTH_W-1:0] WIDTH_RESET = 8'h28;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_DISCHARGE,
        PH_CONVERT
    } ssat_phase_t;

    typedef struct packed {
        logic                  rate_fast;
        logic [AUX_W-1:0]      aux_sel;
    } ssat_mode_t;

    typedef struct packed {
        logic                  wr_pend;
        logic [7:0]            wr_ofs;
        logic [31:0]           rdata;
        ssat_mode_t            mode;
        logic [WIDTH_W-1:0]    sync_width;
        logic [TRIM_W-1:0]     trim;
        ssat_phase_t           phase;
        logic [WIDTH_W-1:0]    width_cnt;
        logic                  div_tick;
        logic [TIMER_W-1:0]    timer;
        logic [CHANNELS-1:0]   trip_prev;
        logic [CHANNELS-1:0]   tripped;
        logic [CHANNELS-1:0][TIMER_W-1:0] work;
        logic [CHANNELS-1:0][TIMER_W-1:0] result;
        logic                  sync_out;
        logic                  sh_strobe;
    } ssat_state_t;

endpackage : ssat_pkg

// ==== verilog/ssat_sync.sv ====
// Two-flop synchroniser for a bus of asynchronous levels.
// Assumes inputs change slowly against the system clock.
`timescale 1ns/100ps
`default_nettype none

module ssat_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } ssat_sync_state_t;

    ssat_sync_state_t state_reg;
    ssat_sync_state_t state_next;

    always_comb begin
        state_next        = state_reg;
        state_next.meta   = async_in;
        state_next.stable = state_reg.meta;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sync_out = state_reg.stable;

endmodule : ssat_sync

`default_nettype wire

// ==== test/ssat_analog_model.sv ====
// Ramp, comparator and input multiplexer model of the analogue side.
// Assumes one ramp step per hclk once the discharge pulse has ended.
`timescale 1ns/100ps
`default_nettype none

module ssat_analog_model
    import ssat_pkg::*;
(
    input  wire logic                hclk,
    input  wire logic                pwm_sync_pulse,
    input  wire logic                sample_hold_strobe,
    input  wire logic                aux_select_high,
    input  wire logic                aux_select_low,
    input  wire logic [TRIM_W-1:0]   ramp_current_trim,
    input  wire logic [6:0][15:0]    thr,
    output logic      [CHANNELS-1:0] comparator_trip,
    output logic      [15:0]         held_sense
);
    // ----------------------------------------------------------------
    // Ramp, hold and comparators
    // ----------------------------------------------------------------
    logic [15:0] ramp = 16'hFFFF;
    logic [15:0] aux_thr;

    initial held_sense = 16'h0000;

    always @(posedge hclk) begin
        if (pwm_sync_pulse)
            ramp <= 16'h0000;
        else if (ramp != 16'hFFFF)
            ramp <= ramp + 16'h0001;
        if (sample_hold_strobe)
            held_sense <= thr[2];
    end

    // Reference crossing comes four steps earlier per trim step
    assign aux_thr = ({aux_select_high, aux_select_low} == 2'b11)
        ? thr[6] - 16'({ramp_current_trim, 2'b00}) : thr[3 + {aux_select_high, aux_select_low}];

    always_comb begin
        for (int i = 0; i < 3; i++)
            comparator_trip[i] = !pwm_sync_pulse && ramp >= thr[i];
        comparator_trip[3] = !pwm_sync_pulse && ramp >= aux_thr;
    end
endmodule : ssat_analog_model

`default_nettype wire

// ==== test/ssat_adc_timer_sva.sv ====
// Port checks of the converter timer, bound into every instance.
// Assumes one hclk domain with an active-low asynchronous reset.
`timescale 1ns/100ps
`default_nettype none

module ssat_adc_timer_sva
    import ssat_pkg::*;
(
    input wire logic              hclk,
    input wire logic              hresetn,
    input wire logic              hsel,
    input wire logic [31:0]       haddr,
    input wire logic [1:0]        htrans,
    input wire logic              hwrite,
    input wire logic              hready,
    input wire logic [31:0]       hwdata,
    input wire logic              pwm_sync_start,
    input wire logic              pwm_sync_pulse,
    input wire logic              sample_hold_strobe,
    input wire logic              aux_select_high,
    input wire logic              aux_select_low,
    input wire logic [TRIM_W-1:0] ramp_current_trim
);
    // ----------------------------------------------------------------
    // Write tracking and pulse length
    // ----------------------------------------------------------------
    logic               wr_dp;
    logic [7:0]         wr_ofs;
    logic [WIDTH_W-1:0] width_q;
    logic [WIDTH_W-1:0] width_eff;
    logic [8:0]         hi_cnt;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_dp   <= 1'b0;
            wr_ofs  <= 8'h00;
            width_q <= WIDTH_RESET;
            hi_cnt  <= 9'h000;
        end else begin
            wr_dp  <= hsel && htrans[1] && hready && hwrite;
            wr_ofs <= {haddr[7:2], 2'b00};
            if (wr_dp && wr_ofs == OFS_SYNC_WT)
                width_q <= hwdata[WIDTH_W-1:0];
            hi_cnt <= pwm_sync_pulse ? hi_cnt + 9'h001 : 9'h000;
        end
    end

    assign width_eff = (width_q == 8'h00) ? 8'h01 :
                       (width_q > SYNC_MAX_CYC) ? SYNC_MAX_CYC : width_q;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sync_rise_a: assert property (pwm_sync_start |=> pwm_sync_pulse)
        else $error("discharge pulse missing after start");
    pulse_cause_a: assert property ($rose(pwm_sync_pulse) |-> $past(pwm_sync_start))
        else $error("discharge pulse without start");
    strobe_fall_a: assert property (sample_hold_strobe == $fell(pwm_sync_pulse))
        else $error("hold strobe not at pulse fall");
    pulse_width_a: assert property ($fell(pwm_sync_pulse) |-> hi_cnt == 9'(width_eff))
        else $error("discharge pulse width wrong");
    pulse_cap_a: assert property (hi_cnt <= 9'(SYNC_MAX_CYC))
        else $error("discharge pulse too long");
    aux_write_a: assert property ($changed({aux_select_high, aux_select_low}) |->
        $past(wr_dp && wr_ofs == OFS_MODE) &&
        {aux_select_high, aux_select_low} == $past(hwdata[1:0]))
        else $error("aux select changed without mode write");
    trim_write_a: assert property ($changed(ramp_current_trim) |->
        $past(wr_dp && wr_ofs == OFS_TRIM) && ramp_current_trim == $past(hwdata[2:0]))
        else $error("trim changed without trim write");
    reset_vals_a: assert property ($rose(hresetn) |-> ramp_current_trim == TRIM_RESET
        && {aux_select_high, aux_select_low} == AUX_RESET && !pwm_sync_pulse)
        else $error("outputs not at reset values");

    strobe_c: cover property (sample_hold_strobe);
    cal_sel_c: cover property (aux_select_high && aux_select_low);
    trim_max_c: cover property (ramp_current_trim == 3'h7);
endmodule : ssat_adc_timer_sva

bind ssat_adc_timer ssat_adc_timer_sva u_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
    .pwm_sync_start(pwm_sync_start), .pwm_sync_pulse(pwm_sync_pulse),
    .sample_hold_strobe(sample_hold_strobe), .aux_select_high(aux_select_high),
    .aux_select_low(aux_select_low), .ramp_current_trim(ramp_current_trim));

`default_nettype wire

// ==== test/single_slope_adc_timer_tb.sv ====
// Bench: AHB-Lite register tests and conversions against the analogue model.
// Assumes a 20 MHz hclk and the register map of the package.
`timescale 1ns/100ps
`default_nettype none

module single_slope_adc_timer_tb
    import ssat_pkg::*;
;
    // ----------------------------------------------------------------
    // Signals, design and model
    // ----------------------------------------------------------------
    logic                hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic                pwm_sync_start = 1'b0;
    logic [31:0]         haddr = 32'h0, hwdata = 32'h0, rd, v, hrdata;
    logic [1:0]          htrans = 2'h0;
    logic                hreadyout, hresp, pwm_sync_pulse, sample_hold_strobe;
    logic                aux_select_high, aux_select_low;
    logic [TRIM_W-1:0]   ramp_current_trim;
    logic [CHANNELS-1:0] comparator_trip;
    logic [15:0]         held_sense;
    logic [6:0][15:0]    thr = '0, t;
    int                  fails = 0, samples_checked = 0, cycles = 0, w;
    logic [7:0]  rst_ofs [9] = '{OFS_MODE, OFS_SYNC_WT, OFS_TRIM, OFS_CAP0, OFS_CAP1,
                                 OFS_CAP2, OFS_CAP3, 8'h20, OFS_STATUS};
    logic [31:0] rst_val [9] = '{32'h0, 32'(WIDTH_RESET), 32'(TRIM_RESET), 32'h0, 32'h0,
                                 32'h0, 32'h0, 32'h0, 32'h0};

    ssat_adc_timer u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .pwm_sync_start(pwm_sync_start), .comparator_trip(comparator_trip),
        .pwm_sync_pulse(pwm_sync_pulse), .sample_hold_strobe(sample_hold_strobe),
        .aux_select_high(aux_select_high), .aux_select_low(aux_select_low),
        .ramp_current_trim(ramp_current_trim));
    ssat_analog_model u_model (.hclk(hclk), .pwm_sync_pulse(pwm_sync_pulse),
        .sample_hold_strobe(sample_hold_strobe), .aux_select_high(aux_select_high),
        .aux_select_low(aux_select_low), .ramp_current_trim(ramp_current_trim),
        .thr(thr), .comparator_trip(comparator_trip),
        .held_sense(held_sense));

    initial forever #25 hclk = ~hclk;

    // ----------------------------------------------------------------
    // Tasks and reference
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] q);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
        chk("hresp", 32'h0, 32'(hresp));
    endtask : bus

    task automatic kick(input int p);
        pwm_sync_start <= 1'b1;
        @(posedge hclk);
        pwm_sync_start <= 1'b0;
        repeat (p - 1) @(posedge hclk);
    endtask : kick

    // Cycles from start to capture: conversion start offset plus two sync stages
    function automatic logic [31:0] expect_cap(input logic rate, input int th, input int avail);
        int k;
        k = th + 2;
        if (k + 1 > avail)
            return 32'h0;
        if (!rate)
            k = k / 2;
        return (k > 4095) ? 32'(TIMER_MAX) : 32'(k);
    endfunction : expect_cap

    task automatic run_conv(input logic rate, input int a, input int p);
        int th;
        bus(1'b1, OFS_MODE, {24'h0, rate, 5'h0, 2'(a)}, rd);
        bus(1'b0, OFS_MODE, 32'h0, rd);
        chk("mode read", {24'h0, rate, 5'h0, 2'(a)}, rd);
        chk("aux pins", 32'(a), 32'({aux_select_high, aux_select_low}));
        thr <= t;
        kick(p);
        kick(w + 4);
        for (int c = 0; c < 4; c++) begin
            bus(1'b0, rst_ofs[3 + c], 32'h0, rd);
            th = (c == 3 && a == 3) ? 16'(t[6] - 16'(4 * v)) : t[(c < 3) ? c : 3 + a];
            chk("capture", expect_cap(rate, th, p - w - 1), rd);
        end
        chk("held sense", 32'(t[2]), 32'(held_sense));
        bus(1'b1, OFS_CAP0, 32'h0000_0ABC, rd);
        bus(1'b0, OFS_CAP0, 32'h0, rd);
        chk("capture kept", expect_cap(rate, t[0], p - w - 1), rd);
        $display("test conversion rate %0d aux %0d done", rate, a);
    endtask : run_conv

    // ----------------------------------------------------------------
    // Main sequence and timeout
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(65));
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 9; i++) begin
            bus(1'b0, rst_ofs[i], 32'h0, rd);
            chk("reset value", rst_val[i], rd);
        end
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            v = (i == 0) ? 32'h7 : (i == 1) ? 32'h0 : 32'($urandom_range(7));
            bus(1'b1, OFS_TRIM, v | 32'hFFFF_FFF8, rd);
            bus(1'b0, OFS_TRIM, 32'h0, rd);
            chk("trim read", v, rd);
            chk("trim pin", v, 32'(ramp_current_trim));
        end
        $display("test trim done");
        w = 2 + $urandom_range(9);
        bus(1'b1, OFS_SYNC_WT, 32'(w), rd);
        bus(1'b0, OFS_SYNC_WT, 32'h0, rd);
        chk("sync width", 32'(w), rd);
        for (int r = 0; r < 2; r++) begin
            for (int a = 0; a < 4; a++) begin
                for (int c = 0; c < 7; c++)
                    t[c] = 16'(1 + $urandom_range(39));
                t[$urandom_range(6)] = 16'h7FFF;
                run_conv(1'(r), a, w + 80);
            end
        end
        t = {7{16'h1068}};
        run_conv(1'b1, 0, 4300);
        // Calibration: zero trim, raise it while reference count exceeds 80 * 2.5 / 3.5
        t = {7{16'h003C}};
        v = 32'h0;
        do begin
            bus(1'b1, OFS_TRIM, v, rd);
            run_conv(1'b1, 3, w + 80);
            bus(1'b0, OFS_CAP3, 32'h0, rd);
            v = v + 32'h1;
        end while (rd > 32'(80 * 5 / 7) && v < 32'h8);
        chk("calibrated trim", 32'h2, 32'(ramp_current_trim));
        $display("test calibration done");
        wrap_up();
    end

    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            wrap_up();
        end
    end
endmodule : single_slope_adc_timer_tb

`default_nettype wire
